// ---- rtl/ctrl_map.svh ----
// Purpose: Register offsets, field positions, reset values and timing figures of the control block.
// Assumes: Included by its bare name wherever a figure is needed.
// Notes: Each alias sits at its register's offset plus the alias step.
`ifndef CTRL_MAP_SVH
`define CTRL_MAP_SVH
////////////////////////////////////////////////////////////////////////////////
`define CON1_OFF 8'h00
`define CON2_OFF 8'h10
`define TXST_OFF 8'h20
`define WMARK_OFF 8'h30
`define STAT_OFF 8'h40
`define ALIAS_CLR 2'h1
`define ALIAS_SET 2'h2
`define ALIAS_INV 2'h3
`define ALIAS_LSB 2
`define ALIAS_MSB 3
////////////////////////////////////////////////////////////////////////////////
`define CON1_WMASK 32'hFFFFA390
`define CON2_WMASK 32'h000007F0
`define TXST_WMASK 32'hFFFFFFFC
`define WMARK_WMASK 32'h0000FFFF
`define CON1_RST 32'h00000000
`define CON2_RST 32'h00000000
`define TXST_RST 32'h00000000
`define WMARK_RST 32'h00000408
////////////////////////////////////////////////////////////////////////////////
`define PTV_LSB 16
`define PTV_MSB 31
`define ON_BIT 15
`define IDLE_STOP_BIT 13
`define TXREQ_BIT 9
`define RECEIVE_ENABLE_BIT 8
`define AUTOMATIC_FLOW_CONTROL_BIT 7
`define MANUAL_FLOW_CONTROL_BIT 4
`define BUFDEC_BIT 0
`define RECEIVE_BUFFER_SIZE_LSB 4
`define RECEIVE_BUFFER_SIZE_MSB 10
`define WM_FULL_LSB 0
`define WM_EMPTY_LSB 8
`define STAT_COUNT_LSB 16
`define STAT_FLOW_BIT 0
`define STAT_TX_BIT 1
`define STAT_RX_BIT 2
`define STAT_PAUSE_BIT 3
////////////////////////////////////////////////////////////////////////////////
`define CLK_KHZ 50000
`define TXCLK10_KHZ 2500
`define TXCLK100_KHZ 25000
`define PAUSE_QUANTA 128
`endif

// ---- rtl/ctrl_pkg.sv ----
// Purpose: Types shared by the control block and its pause generator.
// Assumes: Figures live in ctrl_map.svh.
// Notes: Pause states are one-hot.
package ctrl_pkg;
  typedef enum logic [3:0] {
    PS_IDLE = 4'b0001,
    PS_SEND_ON = 4'b0010,
    PS_WAIT = 4'b0100,
    PS_SEND_OFF = 4'b1000
  } pause_state_t;
  typedef logic [15:0] pause_time_t;
endpackage : ctrl_pkg

// ---- rtl/pause_gen.sv ----
// Purpose: Issues PAUSE frame requests and times their repetition on the TX clock rate.
// Assumes: Requests are taken when req_valid and req_ready are both high.
// Notes: The TX clock rate is a one-cycle enable from a divider of the main clock.
`timescale 1ns/10ps
`include "ctrl_map.svh"
module pause_gen #(
  parameter int QUANTA = `PAUSE_QUANTA
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic hold,
  input wire logic flow_on,
  input wire logic link_speed_100,
  input wire ctrl_pkg::pause_time_t pause_timer_value,
  input wire logic req_ready,
  output logic req_valid,
  output ctrl_pkg::pause_time_t req_time
);
  import ctrl_pkg::*;
  localparam logic [4:0] DIV10 = 5'(`CLK_KHZ / `TXCLK10_KHZ);
  localparam logic [4:0] DIV100 = 5'(`CLK_KHZ / `TXCLK100_KHZ);
  localparam logic [7:0] HALF_QUANTA = 8'(QUANTA / 2);
  pause_state_t state_q;
  logic [4:0] div_q;
  logic tick_q;
  logic [23:0] wait_q;
  ////////////////////////////////////////////////////////////////////////////////
  // The divider free-runs so a speed change takes effect within one TX period.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 5'h00;
      tick_q <= 1'b0;
    end
    else if (div_q >= (link_speed_100 ? DIV100 : DIV10) - 5'h01)
    begin
      div_q <= 5'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 5'h01;
      tick_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= PS_IDLE;
      wait_q <= 24'h000000;
    end
    else if (!enable)
    begin
      state_q <= PS_IDLE;
      wait_q <= 24'h000000;
    end
    else if (!hold)
    begin
      case (state_q)
        PS_IDLE:
        begin
          if (flow_on)
          begin
            state_q <= PS_SEND_ON;
          end
        end
        PS_SEND_ON:
        begin
          if (req_ready)
          begin
            state_q <= PS_WAIT;
            wait_q <= 24'(HALF_QUANTA) * 24'(pause_timer_value);
          end
        end
        PS_WAIT:
        begin
          if (!flow_on)
          begin
            state_q <= PS_SEND_OFF;
          end
          else if (tick_q)
          begin
            if (wait_q <= 24'h000001)
            begin
              state_q <= PS_SEND_ON;
            end
            wait_q <= wait_q - 24'h000001;
          end
        end
        PS_SEND_OFF:
        begin
          if (req_ready)
          begin
            state_q <= PS_IDLE;
          end
        end
        default:
        begin
          state_q <= PS_IDLE;
        end
      endcase
    end
  end
  // A frozen generator must not offer its request, or the buffer would take it again every cycle.
  assign req_valid = enable && !hold && ((state_q == PS_SEND_ON) || (state_q == PS_SEND_OFF));
  assign req_time = (state_q == PS_SEND_ON) ? pause_timer_value : 16'h0000;
endmodule : pause_gen

// ---- rtl/skid_buffer.sv ----
// Purpose: Two-entry buffer with valid and ready on both sides and registered outputs.
// Assumes: Source holds data while valid and not ready.
// Notes: Ready toward the source is low only while the spare entry is occupied.
`timescale 1ns/10ps
module skid_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic spare_valid_q;
  logic [WIDTH-1:0] spare_q;
  logic in_fire;
  assign in_fire = in_valid && !spare_valid_q;
  assign in_ready = !spare_valid_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
      spare_valid_q <= 1'b0;
      spare_q <= '0;
    end
    else if (out_ready || !out_valid)
    begin
      if (spare_valid_q)
      begin
        out_data <= spare_q;
        out_valid <= 1'b1;
        spare_valid_q <= 1'b0;
      end
      else
      begin
        out_data <= in_fire ? in_data : out_data;
        out_valid <= in_fire;
      end
    end
    else if (in_fire)
    begin
      spare_q <= in_data;
      spare_valid_q <= 1'b1;
    end
  end
endmodule : skid_buffer

// ---- rtl/ethernet_ctrl_flow_control.sv ----
// Purpose: Control registers, transmit and receive enables and PAUSE flow control of the Ethernet block.
// Assumes: Register port strobes are one cycle long; read data appears the cycle after the strobe.
// Notes: PAUSE requests leave through a two-entry buffer so a stalled transmitter loses none.
// What this block does
// - Clear, set, invert aliases at plus 4, 8, 12.
// - Enable bit switches transfers, flow control and pause generator on and off; a request held in the buffer still leaves.
// - Idle stop pauses transfers during system idle.
// - Transmit request starts sending, clears when done.
// - Clearing request drops tx_run the next cycle, without waiting for tx_all_done.
// - Receive enable gates storing of received packets.
// - Automatic flow control follows full and empty watermarks.
// - Manual flow control repeats pause every 64 times value.
// - TX clock rate 2.5 or 25 MHz.
// - Leaving flow control sends one zero pause.
// - Decrement bit reads zero, writing one decrements count.
// - Simultaneous increment and decrement keep the count.
// - Seven-bit buffer size in 16-byte steps.
// - Unimplemented bits read zero, writes ignored.
// - Descriptor table address low two bits zero.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "ctrl_map.svh"
module ethernet_ctrl_flow_control #(
  parameter int COUNT_W = 8,
  parameter int PAUSE_QUANTA_TX_CYCLES = `PAUSE_QUANTA
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic system_idle,
  input wire logic link_speed_100,
  input wire logic tx_all_done,
  input wire logic rx_buffer_filled,
  input wire logic pause_ready,
  output logic pause_valid,
  output ctrl_pkg::pause_time_t pause_time,
  output logic tx_run,
  output logic rx_run,
  output logic flow_active,
  output logic [6:0] receive_buffer_size,
  output logic [31:0] tx_table_addr
);
  import ctrl_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [31:0] con1_q;
  logic [31:0] con2_q;
  logic [31:0] txst_q;
  logic [31:0] wmark_q;
  logic [COUNT_W-1:0] count_q;
  logic flow_auto_q;
  logic [7:0] base;
  logic [1:0] kind;
  logic wr_con1;
  logic wr_con2;
  logic wr_txst;
  logic wr_wmark;
  logic [31:0] con1_d;
  logic dec_req;
  logic inc_req;
  logic paused;
  logic gen_valid;
  logic gen_ready;
  pause_time_t gen_time;
  logic [COUNT_W-1:0] full_mark;
  logic [COUNT_W-1:0] empty_mark;
  ////////////////////////////////////////////////////////////////////////////////
  // Applies a plain, clear, set or invert write and keeps unimplemented bits at zero.
  function automatic logic [31:0] apply(input logic [31:0] old, input logic [31:0] w,
                                        input logic [1:0] k, input logic [31:0] mask);
    logic [31:0] r;
    r = w;
    if (k == `ALIAS_CLR)
    begin
      r = old & ~w;
    end
    else if (k == `ALIAS_SET)
    begin
      r = old | w;
    end
    else if (k == `ALIAS_INV)
    begin
      r = old ^ w;
    end
    return r & mask;
  endfunction : apply
  ////////////////////////////////////////////////////////////////////////////////
  // Reset is released through two flip-flops; only the second is used.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync_q <= 2'b00;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  ////////////////////////////////////////////////////////////////////////////////
  assign kind = addr[`ALIAS_MSB:`ALIAS_LSB];
  assign base = {addr[7:`ALIAS_MSB+1], 2'b00, addr[1:0]};
  always_comb
  begin
    wr_con1 = 1'b0;
    wr_con2 = 1'b0;
    wr_txst = 1'b0;
    wr_wmark = 1'b0;
    if (wr && base == `CON1_OFF)
    begin
      wr_con1 = 1'b1;
    end
    else if (wr && base == `CON2_OFF)
    begin
      wr_con2 = 1'b1;
    end
    else if (wr && base == `TXST_OFF)
    begin
      wr_txst = 1'b1;
    end
    else if (wr && base == `WMARK_OFF)
    begin
      wr_wmark = 1'b1;
    end
  end
  // A one written through the plain, set or invert port asks for one decrement.
  assign dec_req = wr_con1 && (kind != `ALIAS_CLR) && wdata[`BUFDEC_BIT];
  assign inc_req = rx_buffer_filled && rx_run;
  // A completion in the same cycle as an alias write still clears the request unless the write sets it.
  assign con1_d = apply(tx_all_done ? (con1_q & ~(32'h00000001 << `TXREQ_BIT)) : con1_q, wdata, kind, `CON1_WMASK);
  ////////////////////////////////////////////////////////////////////////////////
  // A software write in the same cycle as transmit completion wins, so a fresh request is kept.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      con1_q <= `CON1_RST;
    end
    else if (wr_con1)
    begin
      con1_q <= con1_d;
    end
    else if (tx_all_done)
    begin
      con1_q[`TXREQ_BIT] <= 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      con2_q <= `CON2_RST;
      txst_q <= `TXST_RST;
      wmark_q <= `WMARK_RST;
    end
    else
    begin
      if (wr_con2)
      begin
        con2_q <= apply(con2_q, wdata, kind, `CON2_WMASK);
      end
      if (wr_txst)
      begin
        txst_q <= apply(txst_q, wdata, kind, `TXST_WMASK);
      end
      if (wr_wmark)
      begin
        wmark_q <= apply(wmark_q, wdata, kind, `WMARK_WMASK);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // The count saturates at both ends rather than wrapping.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
    end
    else if (inc_req && dec_req)
    begin
      count_q <= count_q;
    end
    else if (inc_req && count_q != '1)
    begin
      count_q <= count_q + 1'b1;
    end
    else if (dec_req && count_q != '0)
    begin
      count_q <= count_q - 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  assign full_mark = COUNT_W'(wmark_q[`WM_FULL_LSB+:8]);
  assign empty_mark = COUNT_W'(wmark_q[`WM_EMPTY_LSB+:8]);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flow_auto_q <= 1'b0;
    end
    else if (!con1_q[`AUTOMATIC_FLOW_CONTROL_BIT])
    begin
      flow_auto_q <= 1'b0;
    end
    else if (count_q >= full_mark)
    begin
      flow_auto_q <= 1'b1;
    end
    else if (count_q <= empty_mark)
    begin
      flow_auto_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  assign paused = con1_q[`IDLE_STOP_BIT] && system_idle;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_run <= 1'b0;
      rx_run <= 1'b0;
      flow_active <= 1'b0;
    end
    else
    begin
      tx_run <= con1_q[`ON_BIT] && con1_q[`TXREQ_BIT] && !paused;
      rx_run <= con1_q[`ON_BIT] && con1_q[`RECEIVE_ENABLE_BIT] && !paused;
      flow_active <= con1_q[`ON_BIT] && (con1_q[`MANUAL_FLOW_CONTROL_BIT] || (con1_q[`AUTOMATIC_FLOW_CONTROL_BIT] && flow_auto_q));
    end
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      receive_buffer_size <= 7'h00;
      tx_table_addr <= 32'h00000000;
    end
    else
    begin
      receive_buffer_size <= con2_q[`RECEIVE_BUFFER_SIZE_MSB:`RECEIVE_BUFFER_SIZE_LSB];
      tx_table_addr <= txst_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  pause_gen #(
    .QUANTA(PAUSE_QUANTA_TX_CYCLES)
  ) u_pause (
    .clock(clock),
    .rst_n(rst_n),
    .enable(con1_q[`ON_BIT]),
    .hold(paused),
    .flow_on(flow_active),
    .link_speed_100(link_speed_100),
    .pause_timer_value(con1_q[`PTV_MSB:`PTV_LSB]),
    .req_ready(gen_ready),
    .req_valid(gen_valid),
    .req_time(gen_time)
  );
  skid_buffer #(
    .WIDTH(16)
  ) u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(gen_valid),
    .in_data(gen_time),
    .in_ready(gen_ready),
    .out_valid(pause_valid),
    .out_data(pause_time),
    .out_ready(pause_ready)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Control register aliases read back the register itself; status aliases and unmapped offsets read zero.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 32'h00000000;
    end
    else if (!rd)
    begin
      rdata <= 32'h00000000;
    end
    else if (base == `CON1_OFF)
    begin
      rdata <= con1_q;
    end
    else if (base == `CON2_OFF)
    begin
      rdata <= con2_q;
    end
    else if (base == `TXST_OFF)
    begin
      rdata <= txst_q;
    end
    else if (base == `WMARK_OFF)
    begin
      rdata <= wmark_q;
    end
    else if (addr == `STAT_OFF)
    begin
      rdata <= 32'h00000000;
      rdata[`STAT_COUNT_LSB+:COUNT_W] <= count_q;
      rdata[`STAT_FLOW_BIT] <= flow_active;
      rdata[`STAT_TX_BIT] <= tx_run;
      rdata[`STAT_RX_BIT] <= rx_run;
      rdata[`STAT_PAUSE_BIT] <= pause_valid;
    end
    else
    begin
      rdata <= 32'h00000000;
    end
  end
endmodule : ethernet_ctrl_flow_control

// ---- dv/flow_ctrl_chk.sv ----
// Purpose: Port checker for the Ethernet control and flow control block.
// Assumes: One clock; strobes one cycle long.
// Notes: Output delays allow three edges so either register stage passes.
`timescale 1ns/10ps
module flow_ctrl_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic tx_all_done,
  input wire logic pause_ready,
  input wire logic pause_valid,
  input wire ctrl_pkg::pause_time_t pause_time,
  input wire logic tx_run,
  input wire logic rx_run,
  input wire logic flow_active,
  input wire logic [6:0] receive_buffer_size,
  input wire logic [31:0] tx_table_addr
);
  import ctrl_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  rdata_quiet_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside a read");
  dec_reads_zero_a: assert property (rd && addr[7:4] == 4'h0 |=> rdata[0] == 1'b0)
    else $error("decrement bit read back as one");
  con1_unused_a: assert property (rd && addr[7:4] == 4'h0 |=> (rdata & ~32'hFFFFA390) == 32'h0)
    else $error("unused bit of first control register set");
  con2_unused_a: assert property (rd && addr[7:4] == 4'h1 |=> rdata[31:11] == 21'h0 && rdata[3:0] == 4'h0)
    else $error("unused bit of second control register set");
  bufsize_copy_a: assert property (rd && addr[7:4] == 4'h1 |=> rdata[10:4] == receive_buffer_size)
    else $error("buffer size output differs from register");
  table_align_a: assert property (tx_table_addr[1:0] == 2'h0)
    else $error("descriptor table address not word aligned");
  table_copy_a: assert property (rd && addr[7:4] == 4'h2 |=> rdata == tx_table_addr)
    else $error("descriptor table output differs from register");
  off_quiet_a: assert property (wr && addr == 8'h04 && wdata[15] |-> ##3 !tx_run && !rx_run && !flow_active)
    else $error("activity after module switched off");
  done_clears_a: assert property (tx_all_done && !wr |-> ##3 !tx_run)
    else $error("transmit still running after all done");
  pause_hold_a: assert property (pause_valid && !pause_ready |=> pause_valid && $stable(pause_time))
    else $error("pause request dropped or changed while stalled");
  pause_start_a: assert property ($rose(flow_active) |-> ##[1:8] pause_valid)
    else $error("no pause request after flow control started");
endmodule : flow_ctrl_chk
bind ethernet_ctrl_flow_control flow_ctrl_chk i_chk (.clock(clock), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_all_done(tx_all_done), .pause_ready(pause_ready),
  .pause_valid(pause_valid), .pause_time(pause_time), .tx_run(tx_run), .rx_run(rx_run),
  .flow_active(flow_active), .receive_buffer_size(receive_buffer_size), .tx_table_addr(tx_table_addr));

// ---- dv/phy_pause_sink.sv ----
// Purpose: Transmit side model that takes PAUSE requests and logs them.
// Assumes: A request is taken on an edge with valid and ready high.
// Notes: Slow mode drops ready at random, so the buffer has to hold requests.
`timescale 1ns/10ps
module phy_pause_sink (
  input wire logic clock,
  input wire logic slow,
  input wire logic stall,
  input wire logic pause_valid,
  input wire ctrl_pkg::pause_time_t pause_time,
  output logic pause_ready
);
  import ctrl_pkg::*;
  pause_time_t got_q[$];
  longint at_q[$];
  longint cyc_q = 0;
  initial pause_ready = 1'b0;
  ////////////////////////////////////////
  always @(posedge clock)
  begin
    cyc_q <= cyc_q + 1;
    if (pause_valid && pause_ready)
    begin
      got_q.push_back(pause_time);
      at_q.push_back(cyc_q);
    end
    pause_ready <= !stall && (!slow || $urandom_range(0, 3) != 0);
  end
endmodule : phy_pause_sink

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the Ethernet control and flow control block.
// Assumes: Pause quanta shortened to 4 so repeat gaps stay short.
// Notes: Expected gaps are worked out from the tick rate of each link speed.
`timescale 1ns/10ps
module tb_top;
  import ctrl_pkg::*;
  localparam int QUANTA = 4;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic system_idle = 1'b0;
  logic link_speed_100 = 1'b0;
  logic tx_all_done = 1'b0;
  logic rx_buffer_filled = 1'b0;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic pause_ready, pause_valid, tx_run, rx_run, flow_active;
  logic [31:0] rdata, tx_table_addr;
  logic [6:0] receive_buffer_size;
  pause_time_t pause_time;
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;
  always #10 clock = ~clock;
  ethernet_ctrl_flow_control #(.PAUSE_QUANTA_TX_CYCLES(QUANTA)) i_ethernet_ctrl_flow_control (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .system_idle(system_idle), .link_speed_100(link_speed_100), .tx_all_done(tx_all_done),
    .rx_buffer_filled(rx_buffer_filled), .pause_ready(pause_ready), .pause_valid(pause_valid),
    .pause_time(pause_time), .tx_run(tx_run), .rx_run(rx_run), .flow_active(flow_active),
    .receive_buffer_size(receive_buffer_size), .tx_table_addr(tx_table_addr));
  phy_pause_sink i_phy_pause_sink (.clock(clock), .slow(slow), .stall(stall),
    .pause_valid(pause_valid), .pause_time(pause_time), .pause_ready(pause_ready));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_n
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clock);
  endtask : rd_reg
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    check(d, e);
  endtask : rchk
  task automatic cnt_chk(input logic [7:0] n);
    logic [31:0] d;
    rd_reg(8'h40, d);
    check({24'h0, d[23:16]}, {24'h0, n});
  endtask : cnt_chk
  task automatic pulse_filled;
    rx_buffer_filled <= 1'b1;
    @(posedge clock);
    rx_buffer_filled <= 1'b0;
    @(posedge clock);
  endtask : pulse_filled
  function automatic logic [31:0] alias_apply(input logic [31:0] e, input int k, input logic [31:0] v);
    return (k == 1) ? (e & ~v) : (k == 2) ? (e | v) : (e ^ v);
  endfunction : alias_apply
  function automatic int gap_of(input int sp, input int p);
    return (QUANTA / 2) * p * ((sp == 1) ? 2 : 20);
  endfunction : gap_of
  task automatic complete_run;
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    logic [31:0] e, v, m;
    logic [7:0] a;
    int k, p, g;
    e = $urandom(6);
    wait_n(4);
    resetn <= 1'b1;
    wait_n(3);
    rchk(8'h00, 32'h0);
    rchk(8'h10, 32'h0);
    rchk(8'h20, 32'h0);
    rchk(8'h30, 32'h00000408);
    wr_reg(8'h00, 32'h00005C6F);
    rchk(8'h00, 32'h0);
    wr_reg(8'h10, 32'hFFFFFFFF);
    rchk(8'h10, 32'h000007F0);
    wr_reg(8'h50, 32'hFFFFFFFF);
    rchk(8'h50, 32'h0);
    $display("test reset and unused bits finished");
    for (int i = 0; i < 16; i++)
    begin
      a = (i % 2) ? 8'h20 : 8'h10;
      m = (i % 2) ? 32'hFFFFFFFC : 32'h000007F0;
      v = $urandom;
      wr_reg(a, v);
      e = v & m;
      k = $urandom_range(1, 3);
      v = $urandom;
      wr_reg(a | 8'(k << 2), v);
      e = alias_apply(e, k, v) & m;
      rchk(a, e);
      check((i % 2) ? tx_table_addr : {21'h0, receive_buffer_size, 4'h0}, e);
    end
    $display("test aliases finished");
    wr_reg(8'h08, 32'h0000A300);
    wait_n(3);
    check({30'h0, tx_run, rx_run}, 32'h3);
    system_idle <= 1'b1;
    wait_n(4);
    check({30'h0, tx_run, rx_run}, 32'h0);
    wr_reg(8'h04, 32'h00002000);
    wait_n(3);
    check({30'h0, tx_run, rx_run}, 32'h3);
    system_idle <= 1'b0;
    tx_all_done <= 1'b1;
    @(posedge clock);
    tx_all_done <= 1'b0;
    wait_n(3);
    check({31'h0, tx_run}, 32'h0);
    rchk(8'h00, 32'h00008100);
    wr_reg(8'h08, 32'h00000200);
    wr_reg(8'h04, 32'h00000200);
    wait_n(3);
    check({31'h0, tx_run}, 32'h0);
    wr_reg(8'h04, 32'h00000100);
    repeat (3) pulse_filled();
    cnt_chk(8'h00);
    wr_reg(8'h04, 32'h00008000);
    wait_n(3);
    check({29'h0, tx_run, rx_run, flow_active}, 32'h0);
    $display("test transmit and receive enables finished");
    for (int sp = 0; sp < 2; sp++)
    begin
      link_speed_100 <= sp[0];
      p = $urandom_range(2, 5);
      i_phy_pause_sink.got_q.delete();
      i_phy_pause_sink.at_q.delete();
      wr_reg(8'h00, {p[15:0], 16'h8010});
      wait_n(5 * gap_of(sp, p) + 20);
      wr_reg(8'h04, 32'h00000010);
      wait_n(30);
      g = int'(i_phy_pause_sink.at_q[2] - i_phy_pause_sink.at_q[1]);
      check({16'h0, i_phy_pause_sink.got_q[1]}, {16'h0, p[15:0]});
      check(32'(g >= gap_of(sp, p) - 3 && g <= gap_of(sp, p) + 3), 32'h1);
      check({16'h0, i_phy_pause_sink.got_q[$]}, 32'h0);
      $display("test manual pause at speed %0d finished", sp);
    end
    stall <= 1'b1;
    i_phy_pause_sink.got_q.delete();
    wr_reg(8'h00, 32'h00058010);
    wait_n(40);
    check({31'h0, pause_valid}, 32'h1);
    wr_reg(8'h04, 32'h00000010);
    wait_n(10);
    stall <= 1'b0;
    wait_n(30);
    check({31'h0, pause_valid}, 32'h0);
    check(32'(i_phy_pause_sink.got_q.size() >= 3), 32'h1);
    check({16'h0, i_phy_pause_sink.got_q[0]}, 32'h5);
    check({16'h0, i_phy_pause_sink.got_q[$]}, 32'h0);
    $display("test stalled pause buffer finished");
    slow <= 1'b1;
    link_speed_100 <= 1'b1;
    i_phy_pause_sink.got_q.delete();
    wr_reg(8'h00, 32'h00038000);
    wr_reg(8'h08, 32'h00000180);
    repeat (7) pulse_filled();
    wait_n(3);
    check({31'h0, flow_active}, 32'h0);
    pulse_filled();
    wait_n(3);
    check({31'h0, flow_active}, 32'h1);
    cnt_chk(8'h08);
    wr_reg(8'h08, 32'h00000001);
    cnt_chk(8'h07);
    wr_reg(8'h00, 32'h00038180);
    cnt_chk(8'h07);
    addr <= 8'h08;
    wdata <= 32'h00000001;
    wr <= 1'b1;
    rx_buffer_filled <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    rx_buffer_filled <= 1'b0;
    @(posedge clock);
    cnt_chk(8'h07);
    repeat (2) wr_reg(8'h08, 32'h00000001);
    wait_n(3);
    check({31'h0, flow_active}, 32'h1);
    wr_reg(8'h08, 32'h00000001);
    wait_n(40);
    check({31'h0, flow_active}, 32'h0);
    check({16'h0, i_phy_pause_sink.got_q[0]}, 32'h3);
    check({16'h0, i_phy_pause_sink.got_q[$]}, 32'h0);
    wr_reg(8'h08, 32'h00000010);
    wait_n(20);
    wr_reg(8'h04, 32'h00008000);
    wait_n(20);
    i_phy_pause_sink.got_q.delete();
    wait_n(60);
    check(32'(i_phy_pause_sink.got_q.size()), 32'h0);
    $display("test automatic flow control finished");
    complete_run();
  end
endmodule : tb_top
